// ==== logic/eeprom_ctrl_pkg.sv ====
/*
  constants for the serial eeprom command controller: register offsets, field
  positions, command codes, reset values and timing counts.
  assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package eeprom_ctrl_pkg;
  // register byte offsets
  localparam logic [11:0] CMD_REG_OFS  = 12'h030;
  localparam logic [11:0] DATA_REG_OFS = 12'h034;
  // command register fields
  localparam int BUSY_BIT    = 31;
  localparam int CODE_HI     = 30;
  localparam int CODE_LO     = 28;
  localparam int TIMEOUT_BIT = 10;
  localparam int LOADED_BIT  = 9;
  localparam int ADDR_HI     = 8;
  localparam int ADDR_W      = 9;
  localparam int DATA_W      = 8;
  // command codes
  typedef enum logic [2:0] {
    CMD_READ   = 3'h0,
    CMD_EW_DISABLE = 3'h1,
    CMD_EW_ENABLE  = 3'h2,
    CMD_WRITE      = 3'h3,
    CMD_WRITE_ALL  = 3'h4,
    CMD_ERASE      = 3'h5,
    CMD_ERASE_ALL  = 3'h6,
    CMD_RELOAD = 3'h7
  } command_code_t;
  localparam logic [2:0]        CODE_RESET  = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
  localparam logic [7:0]        SIGNATURE   = 8'ha5;
  localparam logic [ADDR_W-1:0] LAST_ADDR   = 9'h1ff;
  localparam logic [ADDR_W-1:0] CFG_LEN     = 9'h010;
  // timing: 30 ms limit at 20 MHz
  localparam int CLK_HZ         = 20_000_000;
  localparam int TIMEOUT_MS     = 30;
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  // serial bit-time divider
  localparam int SER_DIV        = 4;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== logic/serial_eeprom_command_ctrl.sv ====
/*
  eeprom command and status logic: AXI4-Lite register slave, command sequencer,
  power-up configuration load and a simple bit-serial port to the eeprom.
  assumes all inputs synchronous to CLK_SYS; the eeprom answers on SER_DI.
*/
`timescale 1ns/1ns

module serial_eeprom_command_ctrl
  import eeprom_ctrl_pkg::*;
(
  input  wire logic                          CLK_SYS,
  input  wire logic                          RESETN,
  input  wire logic [11:0]                   S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [31:0]                   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [11:0]                   S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [31:0]                        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY,
  output logic                               SER_CS,
  output logic                               SER_CLK,
  output logic                               SER_DO,
  input  wire logic                          SER_DI,
  output logic                               CFG_BYTE_VALID,
  output logic [eeprom_ctrl_pkg::ADDR_W-1:0] CFG_BYTE_ADDR,
  output logic [eeprom_ctrl_pkg::DATA_W-1:0] CFG_BYTE_DATA,
  output logic                               CFG_COMMIT
);
  import eeprom_ctrl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SHIFT = 3'h1,
    ST_WAIT  = 3'h2,
    ST_NEXT  = 3'h3,
    ST_DONE  = 3'h4
  } seq_state_t;

  // serial frame: start bit, 2-bit opcode, 9-bit address, 8 data bits
  localparam int FRAME_W = 20;

  // opcode bits and address prefix sent for each command
  function automatic logic [FRAME_W-1:0] make_frame(input logic [2:0] code,
                                                    input logic [ADDR_W-1:0] adr,
                                                    input logic [DATA_W-1:0] dat);
    logic [1:0]        op;
    logic [ADDR_W-1:0] a;
    op = 2'h0;
    a  = adr;
    case (code)
      CMD_READ:   op = 2'h2;
      CMD_RELOAD: op = 2'h2;
      CMD_WRITE:  op = 2'h1;
      CMD_ERASE:  op = 2'h3;
      CMD_EW_DISABLE: a = 9'h000;
      CMD_EW_ENABLE:  a = 9'h180;
      CMD_WRITE_ALL:  a = 9'h080;
      CMD_ERASE_ALL:  a = 9'h100;
      default:    op = 2'h0;
    endcase
    make_frame = {1'b1, op, a, dat};
  endfunction

  // commands that expect the eeprom to signal ready after programming
  function automatic logic is_program(input logic [2:0] code);
    is_program = (code == CMD_WRITE) || (code == CMD_WRITE_ALL) ||
                 (code == CMD_ERASE) || (code == CMD_ERASE_ALL);
  endfunction

  // registers
  logic                      busy_q, busy_d;
  logic [2:0]                code_q;
  logic [ADDR_W-1:0]         addr_q;
  logic [DATA_W-1:0]         data_q;
  logic                      tmo_flag_q, loaded_q;
  seq_state_t                st_q, st_d;
  logic [FRAME_W-1:0]        sh_q;
  logic [4:0]                bit_q;
  logic [1:0]                div_q;
  logic [DATA_W-1:0]         rx_q;
  logic [19:0]               tmo_q;
  logic                      load_q;     // sequence is a configuration load
  logic [ADDR_W-1:0]         ld_adr_q;
  logic                      sig_ok_q;
  logic                      cs_q, sclk_q, do_q;
  logic                      cfg_v_q, commit_q;
  logic [ADDR_W-1:0]         cfg_a_q;
  logic [DATA_W-1:0]         cfg_d_q;

  // axi slave registers
  logic                      awr_q, wr_q, bv_q, arr_q, rv_q;
  logic [11:0]               awa_q;
  logic [31:0]               wd_q;
  logic [3:0]                ws_q;
  logic                      aw_have_q, w_have_q;
  logic [31:0]               rd_q;
  logic [1:0]                bresp_q, rresp_q;

  // write decode once both address and data are held
  wire        wr_fire   = aw_have_q && w_have_q && !bv_q;
  wire        wr_cmd    = wr_fire && (awa_q == CMD_REG_OFS);
  wire        wr_dat    = wr_fire && (awa_q == DATA_REG_OFS);
  wire        wr_bad    = wr_fire && !(wr_cmd || wr_dat);
  wire        start_cmd = wr_cmd && ws_q[3] && wd_q[BUSY_BIT] && !busy_q;
  wire        rd_fire   = S_AXI_ARVALID && arr_q;
  wire        rd_cmd    = (S_AXI_ARADDR[11:2] == CMD_REG_OFS[11:2]);
  wire        rd_dat    = (S_AXI_ARADDR[11:2] == DATA_REG_OFS[11:2]);
  wire [31:0] cmd_view  = {busy_q, code_q, 17'h00000, tmo_flag_q, loaded_q, addr_q};

  // serial timing
  wire        tick      = (div_q == 2'(SER_DIV - 1));
  wire        rise      = tick && !sclk_q;
  wire        fall      = tick && sclk_q;
  wire        frame_end = fall && (bit_q == 5'(FRAME_W - 1));
  wire        want_rdy  = is_program(code_q) && !load_q;
  wire        eep_ready = SER_DI;
  wire        tmo_hit   = (tmo_q == 20'(TIMEOUT_CYCLES - 1));
  // address has already stepped past the byte just read: all bytes done
  wire        ld_last   = (ld_adr_q == CFG_LEN);
  wire        sig_now   = (ld_adr_q == 9'h000) && (rx_q == SIGNATURE);

  // sequencer next state
  always_comb begin
    st_d   = st_q;
    busy_d = busy_q;
    case (st_q)
      ST_IDLE:  if (start_cmd) st_d = ST_SHIFT;
      ST_SHIFT: if (frame_end) st_d = want_rdy ? ST_WAIT : ST_NEXT;
      ST_WAIT:  if (eep_ready || tmo_hit) st_d = ST_DONE;
      ST_NEXT:  st_d = (load_q && !ld_last && (sig_ok_q || ld_adr_q == 9'h000) &&
                        !(ld_adr_q == 9'h000 && !sig_ok_q)) ? ST_SHIFT : ST_DONE;
      ST_DONE:  begin
        st_d   = ST_IDLE;
        busy_d = 1'b0;
      end
      default:  st_d = ST_IDLE;
    endcase
  end

  // sequencer state, busy and load tracking
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      st_q     <= ST_SHIFT;
      busy_q   <= 1'b1;
      load_q   <= 1'b1;
      ld_adr_q <= ADDR_RESET;
      sig_ok_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      busy_q <= start_cmd ? 1'b1 : busy_d;
      if (start_cmd) begin
        load_q   <= (wd_q[CODE_HI:CODE_LO] == CMD_RELOAD);
        ld_adr_q <= ADDR_RESET;
        sig_ok_q <= 1'b0;
      end else if (frame_end && load_q) begin
        if (ld_adr_q == 9'h000) sig_ok_q <= sig_now;
        ld_adr_q <= ld_adr_q + 9'h001;
      end
    end
  end

  // serial shifter: frame out msb first, read byte sampled on rising clock
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      div_q  <= 2'h0;
      sclk_q <= 1'b0;
      cs_q   <= 1'b0;
      do_q   <= 1'b0;
      bit_q  <= 5'h00;
      sh_q   <= make_frame(CMD_READ, ADDR_RESET, DATA_RESET);
      rx_q   <= DATA_RESET;
    end else if (st_q == ST_SHIFT) begin
      div_q <= tick ? 2'h0 : div_q + 2'h1;
      cs_q  <= 1'b1;
      if (rise) begin
        sclk_q <= 1'b1;
        do_q   <= sh_q[FRAME_W-1];
        rx_q   <= {rx_q[6:0], SER_DI};
      end
      if (fall) begin
        sclk_q <= 1'b0;
        sh_q   <= {sh_q[FRAME_W-2:0], 1'b0};
        bit_q  <= frame_end ? 5'h00 : bit_q + 5'h01;
      end
    end else begin
      div_q  <= 2'h0;
      sclk_q <= 1'b0;
      cs_q   <= (st_q == ST_WAIT);     // chip select held while polling ready
      do_q   <= 1'b0;
      bit_q  <= 5'h00;
      if (start_cmd)
        sh_q <= make_frame(wd_q[CODE_HI:CODE_LO], wd_q[ADDR_HI:0], data_q);
      else if (st_q == ST_NEXT)
        sh_q <= make_frame(CMD_READ, ld_adr_q, DATA_RESET);
    end
  end

  // time-out counter runs only while polling for program completion
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) tmo_q <= 20'h00000;
    else if (st_q == ST_WAIT && !tmo_hit) tmo_q <= tmo_q + 20'h00001;
    else if (st_q != ST_WAIT) tmo_q <= 20'h00000;
  end

  // command register fields, data register and sticky status flags
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      code_q     <= CODE_RESET;
      addr_q     <= ADDR_RESET;
      data_q     <= DATA_RESET;
      tmo_flag_q <= 1'b0;
      loaded_q   <= 1'b0;
    end else begin
      if (wr_cmd && ws_q[3]) code_q <= wd_q[CODE_HI:CODE_LO];
      if (wr_cmd && ws_q[0]) addr_q[7:0] <= wd_q[7:0];
      if (wr_cmd && ws_q[1]) addr_q[8] <= wd_q[ADDR_HI];
      if (wr_dat && ws_q[0]) data_q <= wd_q[DATA_W-1:0];
      if (frame_end && !load_q && code_q == CMD_READ) data_q <= rx_q;
      // set wins over a write-one clear
      if (st_q == ST_WAIT && !eep_ready && tmo_hit) tmo_flag_q <= 1'b1;
      else if (wr_cmd && ws_q[1] && wd_q[TIMEOUT_BIT]) tmo_flag_q <= 1'b0;
      if (st_q == ST_NEXT && load_q && ld_last && sig_ok_q) loaded_q <= 1'b1;
      else if (wr_cmd && ws_q[1] && wd_q[LOADED_BIT]) loaded_q <= 1'b0;
    end
  end

  // configuration bytes: staged out, committed only after a valid signature
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      cfg_v_q  <= 1'b0;
      cfg_a_q  <= ADDR_RESET;
      cfg_d_q  <= DATA_RESET;
      commit_q <= 1'b0;
    end else begin
      cfg_v_q  <= frame_end && load_q;
      commit_q <= st_q == ST_NEXT && load_q && ld_last && sig_ok_q;
      if (frame_end && load_q) begin
        cfg_a_q <= ld_adr_q;
        cfg_d_q <= rx_q;
      end
    end
  end

  // axi write channels: take address and data in either order
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      awr_q     <= 1'b1;
      wr_q      <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awa_q     <= 12'h000;
      wd_q      <= 32'h00000000;
      ws_q      <= 4'h0;
      bv_q      <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && awr_q) begin
        awa_q     <= {S_AXI_AWADDR[11:2], 2'h0};
        aw_have_q <= 1'b1;
        awr_q     <= 1'b0;
      end
      if (S_AXI_WVALID && wr_q) begin
        wd_q     <= S_AXI_WDATA;
        ws_q     <= S_AXI_WSTRB;
        w_have_q <= 1'b1;
        wr_q     <= 1'b0;
      end
      if (wr_fire) begin
        bv_q      <= 1'b1;
        bresp_q   <= wr_bad ? RESP_SLVERR : RESP_OKAY;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
      if (bv_q && S_AXI_BREADY) begin
        bv_q  <= 1'b0;
        awr_q <= 1'b1;
        wr_q  <= 1'b1;
      end
    end
  end

  // axi read channel: one-cycle registered answer
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      arr_q   <= 1'b1;
      rv_q    <= 1'b0;
      rd_q    <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      arr_q   <= 1'b0;
      rv_q    <= 1'b1;
      rd_q    <= rd_cmd ? cmd_view : rd_dat ? {24'h000000, data_q} : 32'h00000000;
      rresp_q <= (rd_cmd || rd_dat) ? RESP_OKAY : RESP_SLVERR;
    end else if (rv_q && S_AXI_RREADY) begin
      rv_q  <= 1'b0;
      arr_q <= 1'b1;
    end
  end

  // outputs straight from flip-flops
  assign S_AXI_AWREADY  = awr_q;
  assign S_AXI_WREADY   = wr_q;
  assign S_AXI_BVALID   = bv_q;
  assign S_AXI_BRESP    = bresp_q;
  assign S_AXI_ARREADY  = arr_q;
  assign S_AXI_RVALID   = rv_q;
  assign S_AXI_RDATA    = rd_q;
  assign S_AXI_RRESP    = rresp_q;
  assign SER_CS         = cs_q;
  assign SER_CLK        = sclk_q;
  assign SER_DO         = do_q;
  assign CFG_BYTE_VALID = cfg_v_q;
  assign CFG_BYTE_ADDR  = cfg_a_q;
  assign CFG_BYTE_DATA  = cfg_d_q;
  assign CFG_COMMIT     = commit_q;

endmodule // serial_eeprom_command_ctrl

// ==== verification/eeprom_cmd_checker.sv ====
/* checker: bus and serial-port assertions for the eeprom command block.
   assumes it is bound to the top module; one clock, synchronous reset. */
`timescale 1ns/1ns
module eeprom_cmd_checker
  import eeprom_ctrl_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        SER_CS,
  input wire logic        SER_CLK,
  input wire logic        CFG_BYTE_VALID,
  input wire logic [8:0]  CFG_BYTE_ADDR,
  input wire logic        CFG_COMMIT
);
  logic [11:0] ra_q;
  wire         cmd_rd = (ra_q[11:2] == CMD_REG_OFS[11:2]);
  wire         dat_rd = (ra_q[11:2] == DATA_REG_OFS[11:2]);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // read address kept until its answer
  always_ff @(posedge CLK_SYS) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) ra_q <= S_AXI_ARADDR;
  end
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_rsvd_zero: assert property (S_AXI_RVALID && cmd_rd |-> S_AXI_RDATA[27:11] == 17'h0)
    else $error("reserved bits not zero");
  a_data_width: assert property (S_AXI_RVALID && dat_rd |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("data upper bits not zero");
  a_unmapped_read: assert property (S_AXI_RVALID && !cmd_rd && !dat_rd |->
    S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read answer wrong");
  a_clk_in_frame: assert property (SER_CLK |-> SER_CS)
    else $error("serial clock outside frame");
  a_commit_pulse: assert property (CFG_COMMIT |=> !CFG_COMMIT)
    else $error("commit longer than one cycle");
  a_cfg_range: assert property (CFG_BYTE_VALID |-> CFG_BYTE_ADDR < CFG_LEN)
    else $error("config byte address out of range");
endmodule // eeprom_cmd_checker

// ==== verification/eeprom_partner.sv ====
/* behavioural serial eeprom: shifts in the address, answers read data.
   assumes frames of start, 2 opcode, 9 address and 8 data bits, msb first. */
`timescale 1ns/1ns
module eeprom_partner (
  input  wire logic       cs,
  input  wire logic       sclk,
  input  wire logic       sdo,
  input  wire logic [7:0] first_byte,
  output logic            sdi,
  output logic [7:0]      prog_cnt
);
  int         k;
  logic [8:0] adr;
  logic [7:0] val;
  logic [1:0] op;
  logic       ew_en;
  // bit count and answer, stepped on the falling serial clock
  always @(negedge sclk or negedge cs) begin
    if (!cs) begin
      k = 0;
      sdi = 1'b1; // released line sits at the pull-up level
    end else begin
      if (k >= 1 && k < 3) op = {op[0], sdo};
      if (k >= 3 && k < 12) adr = {adr[7:0], sdo};
      // lock commands carry opcode zero and their kind in the top address bits
      if (k == 11) begin
        if (op == 2'h0 && adr[8:7] == 2'h3) ew_en = 1'b1;
        else if (op == 2'h0 && adr[8:7] == 2'h0) ew_en = 1'b0;
        else if (ew_en && op != 2'h2) prog_cnt = prog_cnt + 8'h01;
      end
      val = (adr == 9'h000) ? first_byte : (adr[7:0] ^ 8'h3c);
      if (k >= 11 && k < 19) sdi = val[18-k];
      else sdi = 1'b1; // ready once the frame is over
      k = k + 1;
    end
  end
  initial begin
    sdi      = 1'b1;
    ew_en    = 1'b0;
    prog_cnt = 8'h00;
  end
endmodule // eeprom_partner

// ==== verification/serial_eeprom_command_ctrl_tb_top.sv ====
/* testbench: drives the register bus, checks commands, load and reload.
   assumes the eeprom partner model on the serial pins. */
`timescale 1ns/1ns
module serial_eeprom_command_ctrl_tb_top;
  import eeprom_ctrl_pkg::*;
  logic        CLK_SYS, RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, SER_CS, SER_CLK;
  logic        SER_DO, SER_DI, CFG_BYTE_VALID, CFG_COMMIT;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [8:0]  CFG_BYTE_ADDR;
  logic [7:0]  CFG_BYTE_DATA, first_byte, prog_cnt;
  int          err_total, comparisons, commits, bytes_seen, c0;
  serial_eeprom_command_ctrl i_serial_eeprom_command_ctrl (.CLK_SYS, .RESETN,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .SER_CS, .SER_CLK, .SER_DO, .SER_DI,
    .CFG_BYTE_VALID, .CFG_BYTE_ADDR, .CFG_BYTE_DATA, .CFG_COMMIT);
  eeprom_partner i_eeprom_partner (.cs(SER_CS), .sclk(SER_CLK), .sdo(SER_DO),
    .first_byte, .sdi(SER_DI), .prog_cnt);
  // 20 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    forever begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    forever begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      rd(CMD_REG_OFS);
      if (d[BUSY_BIT] === 1'b0) break;
    end
  endtask
  task automatic t_reset();
    rd(CMD_REG_OFS);
    chk("busy after reset", 32'h1, {31'h0, d[BUSY_BIT]});
    wait_idle();
    chk("command after load", 32'h0000_0200, d);
    chk("load commits", 32'h1, commits);
    chk("load bytes", 32'h10, bytes_seen);
    $display("test reset done");
  endtask
  task automatic t_read();
    for (int i = 0; i < 2; i++) begin
      logic [8:0] a;
      a = (i == 0) ? 9'h005 : 9'h1ff;
      wr(CMD_REG_OFS, {1'b1, 3'h0, 19'h0, a});
      wait_idle();
      chk("command after read", {1'b0, 3'h0, 18'h0, 1'b1, a}, d);
      rd(DATA_REG_OFS);
      chk("read byte", {24'h0, a[7:0] ^ 8'h3c}, d);
    end
    $display("test read done");
  endtask
  task automatic t_codes();
    wr(DATA_REG_OFS, 32'h0000_005a);
    chk("data write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(DATA_REG_OFS);
    chk("data reg", 32'h0000_005a, d);
    wr(CMD_REG_OFS, {1'b1, 3'h3, 19'h0, 9'h0a3});
    wait_idle();
    chk("write before enable", 32'h0, {24'h0, prog_cnt});
    for (int c = 1; c < 7; c++) begin
      wr(CMD_REG_OFS, {1'b1, 3'(c), 19'h0, 9'h0a3});
      wait_idle();
      chk("command done", {1'b0, 3'(c), 18'h0, 1'b1, 9'h0a3}, d);
    end
    chk("programs taken", 32'h4, {24'h0, prog_cnt});
    wr(CMD_REG_OFS, {1'b1, 3'h1, 19'h0, 9'h0a3});
    wait_idle();
    wr(CMD_REG_OFS, {1'b1, 3'h3, 19'h0, 9'h0a3});
    wait_idle();
    chk("write after disable", 32'h4, {24'h0, prog_cnt});
    $display("test codes done");
  endtask
  task automatic t_clear();
    wr(CMD_REG_OFS, 32'h0fff_fa00);
    rd(CMD_REG_OFS);
    chk("flags cleared", 32'h0, d);
    $display("test clear done");
  endtask
  task automatic t_reload(input logic [7:0] sig, input logic [31:0] exp, input int inc);
    first_byte <= sig;
    c0 = commits;
    wr(CMD_REG_OFS, 32'hf000_0000);
    wait_idle();
    chk("command after reload", exp, d);
    chk("reload commits", c0 + inc, commits);
    $display("test reload done");
  endtask
  task automatic t_unmapped();
    rd(12'h0f0);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(12'h0f0, 32'hffff_ffff);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test unmapped done");
  endtask
  // configuration bytes and commits seen on the load port
  always @(posedge CLK_SYS) begin
    if (CFG_COMMIT === 1'b1) commits++;
    if (CFG_BYTE_VALID === 1'b1) begin
      bytes_seen++;
      chk("cfg byte", (CFG_BYTE_ADDR == 9'h0) ? first_byte : CFG_BYTE_ADDR[7:0] ^ 8'h3c,
        CFG_BYTE_DATA);
    end
  end
  // watchdog well above the expected run length
  initial begin
    repeat (60000) @(posedge CLK_SYS);
    err_total++;
    $display("watchdog expired");
    complete_run();
  end
  // main sequence
  initial begin
    {RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 4'h0;
    {S_AXI_ARVALID, S_AXI_RREADY} = 2'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 56'h0;
    S_AXI_WSTRB = 4'hf;
    first_byte = SIGNATURE;
    repeat (4) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    t_reset();
    t_read();
    t_codes();
    t_clear();
    t_reload(8'h00, 32'h7000_0000, 0);
    t_reload(SIGNATURE, 32'h7000_0200, 1);
    t_unmapped();
    complete_run();
  end
endmodule // serial_eeprom_command_ctrl_tb_top
bind serial_eeprom_command_ctrl eeprom_cmd_checker i_eeprom_cmd_checker (.CLK_SYS, .RESETN,
  .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
  .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .S_AXI_RREADY, .SER_CS, .SER_CLK, .CFG_BYTE_VALID, .CFG_BYTE_ADDR,
  .CFG_COMMIT);
